// ==== include/acc_pkg.sv ====
/*
 * Constants for the comparator control block: register offsets, field
 * positions, reset values, interrupt modes and bus response codes.
 * Assumes a 32-bit AXI4-Lite register bus with byte addressing.
 */
package acc_pkg;

   // Bus
   localparam int          ADDR_W = 5;
   localparam int          DATA_W = 32;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // Register offsets
   localparam logic [4:0]  OFS_CMP_CTRL  = 5'h00;
   localparam logic [4:0]  OFS_SFIO      = 5'h04;
   localparam logic [4:0]  OFS_CONV_CTRL = 5'h08;
   localparam logic [4:0]  OFS_CONV_MUX  = 5'h0c;

   // Comparator control and status fields
   localparam int          BIT_PWR_OFF  = 7;
   localparam int          BIT_BG_SEL   = 6;
   localparam int          BIT_RESULT   = 5;
   localparam int          BIT_FLAG     = 4;
   localparam int          BIT_IRQ_EN   = 3;
   localparam int          BIT_CAP_EN   = 2;
   localparam int          BIT_MODE_HI  = 1;
   localparam int          BIT_MODE_LO  = 0;

   // Other fields
   localparam int          BIT_MUX_EN   = 3;
   localparam int          BIT_CONV_EN  = 7;
   localparam int          CHAN_LSB     = 0;
   localparam int          CHAN_W       = 3;
   localparam int          PIN_COUNT    = 8;

   // Reset values
   localparam logic [7:0]  CMP_CTRL_RST  = 8'h00;
   localparam logic [7:0]  SFIO_RST      = 8'h00;
   localparam logic [7:0]  CONV_CTRL_RST = 8'h00;
   localparam logic [7:0]  CONV_MUX_RST  = 8'h00;

   // Interrupt modes
   localparam logic [1:0]  MODE_TOGGLE   = 2'h0;
   localparam logic [1:0]  MODE_RESERVED = 2'h1;
   localparam logic [1:0]  MODE_FALL     = 2'h2;
   localparam logic [1:0]  MODE_RISE     = 2'h3;

endpackage

// ==== include/acc_sync_if.sv ====
/*
 * Carrier between the synchroniser and the control logic.
 * Assumes both ends run on the same clock.
 */
interface acc_sync_if;
   logic raw;
   logic level;
   logic rise;
   logic fall;

   modport sync (input raw, output level, rise, fall);
   modport user (output raw, input level, rise, fall);
endinterface

// ==== design/acc_sync.sv ====
/*
 * Two-stage synchroniser for the raw comparator result, followed by a
 * previous-value stage that yields rise and fall pulses.
 * Assumes aclk is the system clock and the raw input is asynchronous.
 */
module acc_sync
   import acc_pkg::*;
(
   // Clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic clk_en,
   // Carrier
   acc_sync_if.sync  sif
);

   typedef struct packed {
      logic stage1;
      logic stage2;
      logic prev;
   } acc_sync_state_type;

   acc_sync_state_type q;
   acc_sync_state_type d;

   always_comb begin
      d = q;
      if (!aresetn) begin
         d = '0;
      end else if (clk_en) begin
         d.stage1 = sif.raw;
         d.stage2 = q.stage1;
         d.prev   = q.stage2;
      end
   end

   always_ff @(posedge aclk) begin
      q <= d;
   end

   assign sif.level = q.stage2;
   assign sif.rise  = q.stage2 & ~q.prev;
   assign sif.fall  = ~q.stage2 & q.prev;

endmodule

// ==== design/acc_top.sv ====
/*
 * Digital control around an analog comparator: result synchronisation,
 * edge-triggered interrupt flag, request gating, input selection and
 * routing to a timer capture front end, all behind an AXI4-Lite slave.
 * Assumes the analog stage samples the select outputs directly and the
 * timer front end does its own noise cancelling and edge selection.
 */
// Added by the designer: the AXI4-Lite register port and the register offsets.


module acc_top
   import acc_pkg::*;
(
   // Clock, reset, enable
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   input  wire logic                 clk_en,
   // AXI4-Lite write address
   input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [DATA_W-1:0]    s_axi_wdata,
   input  wire logic [DATA_W/8-1:0]  s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [ADDR_W-1:0]    s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   // AXI4-Lite read data
   output logic [DATA_W-1:0]         s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   // Analog comparator stage
   input  wire logic                 comparator_raw,
   output logic                      comparator_power_off,
   output logic                      bandgap_positive_select,
   output logic                      negative_pin_select,
   output logic [PIN_COUNT-1:0]      converter_pin_select,
   // Processor and timer side
   input  wire logic                 global_irq_enable,
   input  wire logic                 vector_ack,
   output logic                      irq_request,
   output logic                      capture_input,
   output logic                      comparator_result
);

   typedef struct packed {
      // Bus slave
      logic              aw_held;
      logic [ADDR_W-1:0] aw_addr;
      logic              w_held;
      logic [7:0]        w_data;
      logic              w_lane0;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              rvalid;
      logic [1:0]        rresp;
      logic [7:0]        rdata;
      // Comparator control and status
      logic              pwr_off;
      logic              bg_sel;
      logic              flag;
      logic              irq_en;
      logic              cap_en;
      logic [1:0]        mode;
      // Loose bits
      logic              mux_en;
      logic              conv_en;
      logic [CHAN_W-1:0] chan;
      // Timer capture drive
      logic              capture;
      // Input steering
      logic              neg_sel;
      logic [PIN_COUNT-1:0] pin_sel;
   } acc_top_state_type;

   acc_top_state_type q;
   acc_top_state_type d;

   acc_sync_if sif ();

   logic event_hit;
   logic commit;
   logic flag_wclr;
   logic use_conv;
   logic [PIN_COUNT-1:0] pin_hot;
   logic [7:0] ctrl_rd;

   assign sif.raw = comparator_raw;

   acc_sync u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .clk_en  (clk_en),
      .sif     (sif)
   );

   // Event select
   always_comb begin
      event_hit = 1'b0;
      unique case (q.mode)
         MODE_TOGGLE: begin
            event_hit = sif.rise | sif.fall;
         end
         MODE_RESERVED: begin
            event_hit = 1'b0;
         end
         MODE_FALL: begin
            event_hit = sif.fall;
         end
         MODE_RISE: begin
            event_hit = sif.rise;
         end
      endcase
   end

   // Control register image; result bit is live
   always_comb begin
      ctrl_rd              = 8'h00;
      ctrl_rd[BIT_PWR_OFF] = q.pwr_off;
      ctrl_rd[BIT_BG_SEL]  = q.bg_sel;
      ctrl_rd[BIT_RESULT]  = sif.level;
      ctrl_rd[BIT_FLAG]    = q.flag;
      ctrl_rd[BIT_IRQ_EN]  = q.irq_en;
      ctrl_rd[BIT_CAP_EN]  = q.cap_en;
      ctrl_rd[BIT_MODE_HI] = q.mode[1];
      ctrl_rd[BIT_MODE_LO] = q.mode[0];
   end

   // Commit waits for a free response slot
   assign commit    = q.aw_held & q.w_held & ~q.bvalid;
   assign flag_wclr = commit & q.w_lane0 & (q.aw_addr == OFS_CMP_CTRL)
                      & q.w_data[BIT_FLAG];

   always_comb begin
      d = q;
      if (!aresetn) begin
         d         = '0;
         d.pwr_off = CMP_CTRL_RST[BIT_PWR_OFF];
         d.bg_sel  = CMP_CTRL_RST[BIT_BG_SEL];
         d.flag    = CMP_CTRL_RST[BIT_FLAG];
         d.irq_en  = CMP_CTRL_RST[BIT_IRQ_EN];
         d.cap_en  = CMP_CTRL_RST[BIT_CAP_EN];
         d.mode    = CMP_CTRL_RST[BIT_MODE_HI:BIT_MODE_LO];
         d.mux_en  = SFIO_RST[BIT_MUX_EN];
         d.conv_en = CONV_CTRL_RST[BIT_CONV_EN];
         d.chan    = CONV_MUX_RST[CHAN_LSB +: CHAN_W];
         d.neg_sel = ~(d.mux_en & ~d.conv_en);
      end else if (clk_en) begin
         // Response handshakes
         if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
         end
         if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
         end

         // Address and data taken in either order
         if (s_axi_awvalid && !q.aw_held) begin
            d.aw_held = 1'b1;
            d.aw_addr = s_axi_awaddr;
         end
         if (s_axi_wvalid && !q.w_held) begin
            d.w_held  = 1'b1;
            d.w_data  = s_axi_wdata[7:0];
            d.w_lane0 = s_axi_wstrb[0];
         end

         // Write once both halves are held
         if (commit) begin
            d.aw_held = 1'b0;
            d.w_held  = 1'b0;
            d.bvalid  = 1'b1;
            d.bresp   = RESP_OKAY;
            unique case (q.aw_addr)
               OFS_CMP_CTRL: begin
                  if (q.w_lane0) begin
                     d.pwr_off = q.w_data[BIT_PWR_OFF];
                     d.bg_sel  = q.w_data[BIT_BG_SEL];
                     d.irq_en  = q.w_data[BIT_IRQ_EN];
                     d.cap_en  = q.w_data[BIT_CAP_EN];
                     d.mode    = q.w_data[BIT_MODE_HI:BIT_MODE_LO];
                  end
               end
               OFS_SFIO: begin
                  if (q.w_lane0) begin
                     d.mux_en = q.w_data[BIT_MUX_EN];
                  end
               end
               OFS_CONV_CTRL: begin
                  if (q.w_lane0) begin
                     d.conv_en = q.w_data[BIT_CONV_EN];
                  end
               end
               OFS_CONV_MUX: begin
                  if (q.w_lane0) begin
                     d.chan = q.w_data[CHAN_LSB +: CHAN_W];
                  end
               end
               default: begin
                  d.bresp = RESP_SLVERR;
               end
            endcase
         end

         // Read answered one cycle after the address is taken
         if (s_axi_arvalid && !q.rvalid) begin
            d.rvalid = 1'b1;
            d.rresp  = RESP_OKAY;
            d.rdata  = 8'h00;
            unique case (s_axi_araddr)
               OFS_CMP_CTRL: begin
                  d.rdata = ctrl_rd;
               end
               OFS_SFIO: begin
                  d.rdata[BIT_MUX_EN] = q.mux_en;
               end
               OFS_CONV_CTRL: begin
                  d.rdata[BIT_CONV_EN] = q.conv_en;
               end
               OFS_CONV_MUX: begin
                  d.rdata[CHAN_LSB +: CHAN_W] = q.chan;
               end
               default: begin
                  d.rresp = RESP_SLVERR;
               end
            endcase
         end

         // Flag: a new event beats any clear in the same cycle
         if (event_hit) begin
            d.flag = 1'b1;
         end else if (flag_wclr || vector_ack) begin
            d.flag = 1'b0;
         end

         // Timer capture path and input steering
         d.capture = q.cap_en & sif.level;
         d.neg_sel = ~use_conv;
         d.pin_sel = pin_hot;
      end
   end

   always_ff @(posedge aclk) begin
      q <= d;
   end

   // Bus outputs
   // Readies stay low while frozen, so nothing is taken then
   assign s_axi_awready = clk_en & ~q.aw_held;
   assign s_axi_wready  = clk_en & ~q.w_held;
   assign s_axi_arready = clk_en & ~q.rvalid;
   assign s_axi_bvalid  = q.bvalid;
   assign s_axi_bresp   = q.bresp;
   assign s_axi_rvalid  = q.rvalid;
   assign s_axi_rresp   = q.rresp;
   assign s_axi_rdata   = {{(DATA_W-8){1'b0}}, q.rdata};

   // Analog and system outputs
   assign comparator_power_off    = q.pwr_off;
   assign bandgap_positive_select = q.bg_sel;
   assign use_conv                = q.mux_en & ~q.conv_en;
   assign negative_pin_select     = q.neg_sel;
   assign converter_pin_select    = q.pin_sel;
   // Level request; the vector handshake lives on the processor side
   assign irq_request = q.flag & q.irq_en & global_irq_enable;
   assign capture_input     = q.capture;
   assign comparator_result = sif.level;

   // One-hot converter pin steering
   for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
      assign pin_hot[i] =
         use_conv & (q.chan == CHAN_W'(i));
   end

endmodule

// ==== test/acc_chk.sv ====
/* Port assertions for acc_top.
   Assumes one clock, aclk, and bind to every acc_top instance. */
module acc_chk
   import acc_pkg::*;
(
   // Clock and reset
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   input  wire logic                 clk_en,
   // Register bus
   input  wire logic                 s_axi_arvalid,
   input  wire logic                 s_axi_arready,
   input  wire logic                 s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   input  wire logic                 s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   // Comparator and processor side
   input  wire logic                 comparator_raw,
   input  wire logic                 negative_pin_select,
   input  wire logic [PIN_COUNT-1:0] converter_pin_select,
   input  wire logic                 global_irq_enable,
   input  wire logic                 vector_ack,
   input  wire logic                 irq_request,
   input  wire logic                 capture_input,
   input  wire logic                 comparator_result
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_sync_delay: assert property (
      $past(clk_en) && $past(clk_en, 2) && $past(aresetn) && $past(aresetn, 2)
      |-> comparator_result == $past(comparator_raw, 2))
      else $error("result not two cycles after raw");
   a_req_gate: assert property (
      irq_request |-> global_irq_enable)
      else $error("request without global enable");
   a_flag_source: assert property (
      $rose(irq_request) && $past(global_irq_enable) && !s_axi_bvalid
      |-> $past(comparator_result) != $past(comparator_result, 2))
      else $error("request rose without result edge");
   a_vector_clear: assert property (
      vector_ack && clk_en && comparator_result == $past(comparator_result)
      |=> !irq_request)
      else $error("vector did not clear request");
   a_capture_path: assert property (
      capture_input |-> $past(comparator_result))
      else $error("capture without result");
   a_neg_pin: assert property (
      negative_pin_select |-> converter_pin_select == '0)
      else $error("converter pin with negative pin");
   a_pin_onehot: assert property (
      !negative_pin_select |-> $onehot(converter_pin_select))
      else $error("converter pin select not one-hot");
   a_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered next cycle");
   a_resp_stands: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   a_flag_holds: assert property (
      irq_request && !vector_ack |=> irq_request || !global_irq_enable
      || $rose(s_axi_bvalid))
      else $error("request dropped without a clear");
endmodule

bind acc_top acc_chk u_chk (.aclk, .aresetn, .clk_en, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid,
   .s_axi_bready, .comparator_raw, .negative_pin_select,
   .converter_pin_select, .global_irq_enable, .vector_ack, .irq_request,
   .capture_input, .comparator_result);

// ==== test/acc_analog_model.sv ====
/* Behavioural analog comparator with its input steering.
   Assumes selects come from acc_top and levels from the bench. */
module acc_analog_model
   import acc_pkg::*;
(
   // Selects from the block
   input  wire logic                 comparator_power_off,
   input  wire logic                 bandgap_positive_select,
   input  wire logic                 negative_pin_select,
   input  wire logic [PIN_COUNT-1:0] converter_pin_select,
   // Input levels
   input  wire logic                 pos_lvl,
   input  wire logic                 bg_lvl,
   input  wire logic                 neg_lvl,
   input  wire logic [PIN_COUNT-1:0] conv_lvl,
   // Result
   output logic                      comparator_raw
);
   timeunit 1ns;
   timeprecision 1ps;
   logic pos;
   logic neg;
   assign pos = bandgap_positive_select ? bg_lvl : pos_lvl;
   assign neg = negative_pin_select ? neg_lvl
              : |(converter_pin_select & conv_lvl);
   // Unpowered stage reads low
   assign comparator_raw = !comparator_power_off && pos && !neg;
endmodule

// ==== test/test_comparator_control_logic.sv ====
/* Self-checking bench for acc_top over AXI4-Lite.
   Assumes acc_analog_model stands for the analog stage. */
module test_comparator_control_logic
   import acc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic                 aclk, aresetn, clk_en, comparator_raw;
   logic [ADDR_W-1:0]    s_axi_awaddr, s_axi_araddr;
   logic [DATA_W-1:0]    s_axi_wdata, s_axi_rdata;
   logic [3:0]           s_axi_wstrb;
   logic [1:0]           s_axi_bresp, s_axi_rresp;
   logic                 s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic                 s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic                 s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic                 s_axi_rready, irq_request, capture_input;
   logic                 comparator_power_off, bandgap_positive_select;
   logic                 negative_pin_select, comparator_result;
   logic [PIN_COUNT-1:0] converter_pin_select, conv_lvl;
   logic                 global_irq_enable, vector_ack;
   logic                 pos_lvl, bg_lvl, neg_lvl;
   int                   errors, n_compared, m;

   acc_top DUT (.aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .comparator_raw,
      .comparator_power_off, .bandgap_positive_select, .negative_pin_select,
      .converter_pin_select, .global_irq_enable, .vector_ack, .irq_request,
      .capture_input, .comparator_result);
   acc_analog_model u_ana (.comparator_power_off, .bandgap_positive_select,
      .negative_pin_select, .converter_pin_select, .pos_lvl, .bg_lvl,
      .neg_lvl, .conv_lvl, .comparator_raw);

   initial begin
      aclk = 0;
      forever #2.5 aclk = ~aclk;
   end
   initial begin
      repeat (20000) @(posedge aclk);
      errors++;
      complete_run();
   end

   task automatic complete_run();
      if (errors == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      logic ta, tw, tb;
      logic [1:0] r;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      do begin
         @(negedge aclk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 0;
         if (tw) s_axi_wvalid <= 0;
      end while ((s_axi_awvalid && !ta) || (s_axi_wvalid && !tw));
      s_axi_bready <= 1;
      do begin
         @(negedge aclk);
         tb = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge aclk);
      end while (!tb);
      s_axi_bready <= 0;
      chk("bresp", er, r);
   endtask

   task automatic rd(input logic [4:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
      logic t;
      logic [31:0] d;
      logic [1:0] r;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(negedge aclk);
         t = s_axi_arready;
         @(posedge aclk);
      end while (!t);
      s_axi_arvalid <= 0;
      do begin
         @(negedge aclk);
         t = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
      end while (!t);
      s_axi_rready <= 0;
      chk("rdata", ed, d);
      chk("rresp", er, r);
   endtask

   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
      {s_axi_arvalid, s_axi_rready, global_irq_enable} = 3'h0;
      {vector_ack, pos_lvl, neg_lvl, conv_lvl} = 11'h000;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 42'h0;
      clk_en = 1;
      bg_lvl = 1;
      s_axi_wstrb = 4'hf;
      repeat (10) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      rd(OFS_CMP_CTRL, 32'h00, RESP_OKAY);
      rd(OFS_SFIO, 32'h00, RESP_OKAY);
      rd(5'h10, 32'h00, RESP_SLVERR);
      wr(5'h14, 32'hff, RESP_SLVERR);
      wr(OFS_CMP_CTRL, 32'hf7, RESP_OKAY);
      @(negedge aclk);
      chk("power_off", 1, comparator_power_off);
      chk("bandgap", 1, bandgap_positive_select);
      rd(OFS_CMP_CTRL, 32'hc7, RESP_OKAY);
      wr(OFS_CMP_CTRL, 32'h44, RESP_OKAY);
      repeat (4) @(negedge aclk);
      chk("capture", 1, capture_input);
      rd(OFS_CMP_CTRL, 32'h74, RESP_OKAY);
      wr(OFS_CMP_CTRL, 32'h50, RESP_OKAY);
      repeat (3) @(negedge aclk);
      chk("capture", 0, capture_input);
      rd(OFS_CMP_CTRL, 32'h60, RESP_OKAY);
      wr(OFS_CMP_CTRL, 32'h00, RESP_OKAY);
      repeat (4) @(posedge aclk);
      wr(OFS_SFIO, 32'hff, RESP_OKAY);
      rd(OFS_SFIO, 32'h08, RESP_OKAY);
      for (m = 0; m < 8; m++) begin
         wr(OFS_CONV_MUX, m, RESP_OKAY);
         @(negedge aclk);
         chk("pin_select", 1 << m, converter_pin_select);
         chk("neg_select", 0, negative_pin_select);
      end
      wr(OFS_CONV_CTRL, 32'h80, RESP_OKAY);
      @(negedge aclk);
      chk("pin_select", 0, converter_pin_select);
      chk("neg_select", 1, negative_pin_select);
      for (m = 0; m < 4; m++) begin
         wr(OFS_CMP_CTRL, 32'h10 | m, RESP_OKAY);
         @(posedge aclk) pos_lvl <= 1;
         repeat (4) @(posedge aclk);
         rd(OFS_CMP_CTRL, 32'h20 | m | ((m == 0 || m == 3) ? 32'h10 : 0),
            RESP_OKAY);
         wr(OFS_CMP_CTRL, 32'h10 | m, RESP_OKAY);
         @(posedge aclk) pos_lvl <= 0;
         repeat (4) @(posedge aclk);
         rd(OFS_CMP_CTRL, m | ((m == 0 || m == 2) ? 32'h10 : 0),
            RESP_OKAY);
      end
      wr(OFS_CMP_CTRL, 32'h0b, RESP_OKAY);
      global_irq_enable <= 1;
      @(posedge aclk) pos_lvl <= 1;
      repeat (4) @(negedge aclk);
      chk("irq", 1, irq_request);
      @(posedge aclk) global_irq_enable <= 0;
      @(negedge aclk) chk("irq", 0, irq_request);
      @(posedge aclk) global_irq_enable <= 1;
      vector_ack <= 1;
      @(posedge aclk) vector_ack <= 0;
      @(negedge aclk) chk("irq", 0, irq_request);
      @(posedge aclk) pos_lvl <= 0;
      repeat (4) @(posedge aclk);
      pos_lvl <= 1;
      repeat (4) @(negedge aclk);
      chk("irq", 1, irq_request);
      wr(OFS_CMP_CTRL, 32'h0b, RESP_OKAY);
      @(negedge aclk) chk("irq", 1, irq_request);
      wr(OFS_CMP_CTRL, 32'h03, RESP_OKAY);
      @(negedge aclk) chk("irq", 0, irq_request);
      wr(OFS_CMP_CTRL, 32'h1b, RESP_OKAY);
      @(negedge aclk) chk("irq", 0, irq_request);
      // Frozen clock enable holds the synchronised result
      @(posedge aclk) clk_en <= 0;
      pos_lvl <= 0;
      repeat (4) @(negedge aclk);
      chk("result", 1, comparator_result);
      @(posedge aclk) clk_en <= 1;
      repeat (3) @(negedge aclk);
      chk("result", 0, comparator_result);
      complete_run();
   end
endmodule
